// ### clbc_map.svh
// Purpose: Register map, field positions, reset values and timing for the colour LED block
// Assumes: 40 MHz mclk, 32-bit AXI4-Lite data, 8-bit registers in the low byte
// Notes  : Register indices are word indices; byte address is four times the index
`ifndef CLBC_MAP_SVH
`define CLBC_MAP_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define CLBC_IDX_LED_OUTPUT_CONTROL      8'h00
`define CLBC_IDX_RED_ONE_ON_OFF_TIME     8'h01
`define CLBC_IDX_RED_ONE_CYCLE           8'h02
`define CLBC_IDX_GREEN_ONE_ON_OFF_TIME   8'h03
`define CLBC_IDX_GREEN_ONE_CYCLE         8'h04
`define CLBC_IDX_BLUE_ONE_ON_OFF_TIME    8'h05
`define CLBC_IDX_BLUE_ONE_CYCLE          8'h06
`define CLBC_IDX_EXTERNAL_DIMMING_SELECT 8'h07
`define CLBC_IDX_COLOUR_MODE_SELECT      8'h10
`define CLBC_IDX_OUTPUT_STATUS           8'h11

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CLBC_BIT_GROUP_ONE_STYLE   7
`define CLBC_BIT_GROUP_TWO_STYLE   6
`define CLBC_BIT_WHITE_A_EXT_DIM   7
`define CLBC_BIT_WHITE_B_EXT_DIM   6
`define CLBC_BIT_BLINK_ENABLE      3
`define CLBC_CYCLE_WRITE_MASK      8'h0F
`define CLBC_MODE_WRITE_MASK       8'h03
`define CLBC_MODE_BLINK_GROUP_ONE  2'h1
`define CLBC_RST_LED_OUTPUT_CONTROL 8'hC0
`define CLBC_RST_OTHER             8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLBC_CLK_PERIOD_PS  25000
`define CLBC_TICK_PS        1000000000
`define CLBC_TICK_CYCLES    (`CLBC_TICK_PS / `CLBC_CLK_PERIOD_PS)
`define CLBC_PERMILLE_FULL  23'h0003E8
// Period per cycle code in ms, code 7 in the top slice
`define CLBC_PERIOD_MS {13'h1388, 13'h0FA0, 13'h0BB8, 13'h07D0, 13'h03E8, 13'h01F4, 13'h00FA, 13'h0064}
// Share of the cycle per on/off code in tenths of a percent, code 15 in the top slice
`define CLBC_SHARE_PERMILLE {10'h3E8, 10'h384, 10'h320, 10'h2BC, 10'h258, 10'h1F4, 10'h190, \
	10'h12C, 10'h0C8, 10'h096, 10'h064, 10'h04B, 10'h032, 10'h019, 10'h00A, 10'h000}

`endif

// ### clbc_pkg.sv
// Purpose: Shared types of the colour LED block
// Assumes: No map header is included; widths are written out here
// Notes  : Nothing here holds a value of its own
package clbc_pkg;
	typedef logic [7:0] clbc_byte_t;

	// Software visible register image
	typedef struct packed {
		clbc_byte_t      led_output_control;
		clbc_byte_t [2:0] on_off_time;     // Index 2 red, 1 green, 0 blue
		clbc_byte_t [2:0] cycle;
		clbc_byte_t      external_dimming_select;
		clbc_byte_t      colour_mode_select;
	} clbc_regs_s;

	// Phase of one blink sequencer
	typedef enum logic [1:0] {
		phase_idle,
		phase_lit,
		phase_dark
	} clbc_phase_e;
endpackage : clbc_pkg

// ### clbc_blink_if.sv
// Purpose: Carries settings and result between the register block and one blink sequencer
// Assumes: Both ends on mclk
// Notes  : tick is a one-cycle pulse every millisecond
`timescale 1ns/1ps
interface clbc_blink_if;
	logic       tick;
	logic       run;
	logic [3:0] on_code;
	logic [3:0] off_code;
	logic [2:0] period_code;
	logic       lit;

	modport seq  (input tick, input run, input on_code, input off_code, input period_code,
		output lit);
	modport ctrl (output tick, output run, output on_code, output off_code, output period_code,
		input lit);
endinterface : clbc_blink_if

// ### clbc_blink.sv
// Purpose: Millisecond blink sequencer for one group-one colour
// Assumes: tick pulses once per millisecond
// Notes  : Off share wins over on share at the end of the cycle
`timescale 1ns/1ps
`include "clbc_map.svh"
module clbc_blink (
	input wire logic     mclk,
	input wire logic     reset,
	clbc_blink_if.seq    bl
);
	localparam logic [103:0] PERIODS = `CLBC_PERIOD_MS;
	localparam logic [159:0] SHARES  = `CLBC_SHARE_PERMILLE;

	typedef struct packed {
		clbc_pkg::clbc_phase_e phase;
		logic [12:0]           cnt;
	} clbc_blink_s;

	clbc_blink_s s_reg;
	clbc_blink_s s_next;
	logic [12:0] period;
	logic [12:0] on_len;
	logic [12:0] off_len;

	function automatic logic [12:0] share_ms(input logic [12:0] per, input logic [3:0] code);
		logic [22:0] prod;
		prod = 23'(per) * 23'(SHARES[code*10 +: 10]);
		return 13'(prod / `CLBC_PERMILLE_FULL);
	endfunction : share_ms

	// Lit while inside the on share and before the trailing off share
	function automatic clbc_pkg::clbc_phase_e phase_at(input logic [12:0] c);
		if (c < on_len && ({1'b0, c} + {1'b0, off_len}) < {1'b0, period}) begin
			return clbc_pkg::phase_lit;
		end
		return clbc_pkg::phase_dark;
	endfunction : phase_at

	assign period  = PERIODS[bl.period_code*13 +: 13];
	assign on_len  = share_ms(period, bl.on_code);
	assign off_len = share_ms(period, bl.off_code);
	assign bl.lit  = (s_reg.phase == clbc_pkg::phase_lit);

	// Sequencer next state; shrinking the period wraps at the next tick
	always_comb begin
		s_next = s_reg;
		unique case (s_reg.phase)
			clbc_pkg::phase_idle: begin
				if (bl.run) begin
					s_next.cnt   = 13'h0000;
					s_next.phase = phase_at(13'h0000);
				end
			end
			clbc_pkg::phase_lit, clbc_pkg::phase_dark: begin
				if (!bl.run) begin
					s_next.phase = clbc_pkg::phase_idle;
				end else if (bl.tick) begin
					s_next.cnt   = (s_reg.cnt + 13'h0001 >= period) ? 13'h0000 : s_reg.cnt + 13'h0001;
					s_next.phase = phase_at(s_next.cnt);
				end else begin
					s_next.phase = phase_at(s_reg.cnt);
				end
			end
			default: s_next.phase = clbc_pkg::phase_idle;
		endcase
	end

	// State register
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s_reg <= '{phase: clbc_pkg::phase_idle, cnt: 13'h0000};
		end else begin
			s_reg <= s_next;
		end
	end
endmodule : clbc_blink

// ### clbc_top.sv
// Purpose: Colour LED enable, blink and external dimming control behind AXI4-Lite
// Assumes: ext_dim_in synchronous to mclk; one outstanding write and read
// Notes  : Outputs are registered and change one cycle after their cause
`timescale 1ns/1ps
`include "clbc_map.svh"
module clbc_top #(
	parameter int ADDR_W      = 8,
	parameter int TICK_CYCLES = `CLBC_TICK_CYCLES
) (
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output wire logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output wire logic              s_axi_wready,
	output wire logic [1:0]        s_axi_bresp,
	output wire logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output wire logic              s_axi_arready,
	output wire logic [31:0]       s_axi_rdata,
	output wire logic [1:0]        s_axi_rresp,
	output wire logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              ext_dim_in,
	output wire logic [5:0]        led_drive,
	output wire logic              group_one_driver_style,
	output wire logic              group_two_driver_style,
	output wire logic              white_bank_a_dim_gate,
	output wire logic              white_bank_b_dim_gate
);
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between 7 and 32");
	end
	if (TICK_CYCLES < 1) begin : g_bad_tick
		$error("TICK_CYCLES must be at least 1");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic                    aw_held;
		logic [ADDR_W-1:0]       aw_addr;
		logic                    w_held;
		logic [31:0]             w_data;
		logic [3:0]              w_strb;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [1:0]              rresp;
		logic [31:0]             rdata;
		logic [TICK_W-1:0]       presc;
		logic                    tick;
		clbc_pkg::clbc_regs_s    regs;
		logic [5:0]              drive;
		logic                    style_one;
		logic                    style_two;
		logic                    gate_a;
		logic                    gate_b;
	} clbc_state_s;

	clbc_state_s s_reg;
	clbc_state_s s_next;
	logic [2:0]  lit;
	logic        blink_mode;

	clbc_blink_if bl [3] ();

	// ----------------------------------------
	// Blink sequencers, one per group-one colour
	// ----------------------------------------
	for (genvar k = 0; k < 3; k++) begin : g_blink
		assign bl[k].tick        = s_reg.tick;
		assign bl[k].run         = blink_mode && s_reg.regs.cycle[k][`CLBC_BIT_BLINK_ENABLE];
		assign bl[k].on_code     = s_reg.regs.on_off_time[k][7:4];
		assign bl[k].off_code    = s_reg.regs.on_off_time[k][3:0];
		assign bl[k].period_code = s_reg.regs.cycle[k][2:0];
		assign lit[k]            = bl[k].lit;

		clbc_blink u_blink (
			.mclk  (mclk),
			.reset (reset),
			.bl    (bl[k])
		);
	end

	assign blink_mode = (s_reg.regs.colour_mode_select[1:0] == `CLBC_MODE_BLINK_GROUP_ONE);

	// ----------------------------------------
	// Bus outputs
	// ----------------------------------------
	// A new address or data beat is refused while the previous response is pending
	assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
	assign s_axi_wready  = !s_reg.w_held && !s_reg.bvalid;
	assign s_axi_bvalid  = s_reg.bvalid;
	assign s_axi_bresp   = s_reg.bresp;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_rvalid  = s_reg.rvalid;
	assign s_axi_rresp   = s_reg.rresp;
	assign s_axi_rdata   = s_reg.rdata;

	// LED side outputs, all from flip-flops
	assign led_drive              = s_reg.drive;
	assign group_one_driver_style = s_reg.style_one;
	assign group_two_driver_style = s_reg.style_two;
	assign white_bank_a_dim_gate  = s_reg.gate_a;
	assign white_bank_b_dim_gate  = s_reg.gate_b;

	// ----------------------------------------
	// Register read decode
	// ----------------------------------------
	function automatic logic [8:0] read_reg(input logic [ADDR_W-1:0] addr,
		input clbc_state_s st);
		logic [7:0] idx;
		logic [8:0] res;
		idx = 8'(addr[ADDR_W-1:2]);
		res = {1'b1, 8'h00};
		unique case (idx)
			`CLBC_IDX_LED_OUTPUT_CONTROL:      res[7:0] = st.regs.led_output_control;
			`CLBC_IDX_RED_ONE_ON_OFF_TIME:     res[7:0] = st.regs.on_off_time[2];
			`CLBC_IDX_GREEN_ONE_ON_OFF_TIME:   res[7:0] = st.regs.on_off_time[1];
			`CLBC_IDX_BLUE_ONE_ON_OFF_TIME:    res[7:0] = st.regs.on_off_time[0];
			`CLBC_IDX_RED_ONE_CYCLE:           res[7:0] = st.regs.cycle[2];
			`CLBC_IDX_GREEN_ONE_CYCLE:         res[7:0] = st.regs.cycle[1];
			`CLBC_IDX_BLUE_ONE_CYCLE:          res[7:0] = st.regs.cycle[0];
			`CLBC_IDX_EXTERNAL_DIMMING_SELECT: res[7:0] = st.regs.external_dimming_select;
			`CLBC_IDX_COLOUR_MODE_SELECT:      res[7:0] = st.regs.colour_mode_select;
			`CLBC_IDX_OUTPUT_STATUS:           res[7:0] = {2'h0, st.drive};
			default:                           res[8]   = 1'b0;
		endcase
		return res;
	endfunction : read_reg

	// ----------------------------------------
	// Register write decode
	// ----------------------------------------
	// Returns the updated image; only byte lane 0 carries register data
	function automatic clbc_pkg::clbc_regs_s write_reg(input logic [7:0] idx,
		input logic [7:0] d, input clbc_pkg::clbc_regs_s r);
		clbc_pkg::clbc_regs_s n;
		n = r;
		unique case (idx)
			`CLBC_IDX_LED_OUTPUT_CONTROL:      n.led_output_control = d;
			`CLBC_IDX_RED_ONE_ON_OFF_TIME:     n.on_off_time[2] = d;
			`CLBC_IDX_GREEN_ONE_ON_OFF_TIME:   n.on_off_time[1] = d;
			`CLBC_IDX_BLUE_ONE_ON_OFF_TIME:    n.on_off_time[0] = d;
			`CLBC_IDX_RED_ONE_CYCLE:           n.cycle[2] = d & `CLBC_CYCLE_WRITE_MASK;
			`CLBC_IDX_GREEN_ONE_CYCLE:         n.cycle[1] = d & `CLBC_CYCLE_WRITE_MASK;
			`CLBC_IDX_BLUE_ONE_CYCLE:          n.cycle[0] = d & `CLBC_CYCLE_WRITE_MASK;
			`CLBC_IDX_EXTERNAL_DIMMING_SELECT: n.external_dimming_select = d;
			`CLBC_IDX_COLOUR_MODE_SELECT:      n.colour_mode_select = d & `CLBC_MODE_WRITE_MASK;
			default:                           n = r;
		endcase
		return n;
	endfunction : write_reg

	// Mapped for writes; the status word accepts and drops the data
	function automatic logic write_hit(input logic [7:0] idx);
		return (idx <= `CLBC_IDX_EXTERNAL_DIMMING_SELECT) ||
			(idx == `CLBC_IDX_COLOUR_MODE_SELECT) || (idx == `CLBC_IDX_OUTPUT_STATUS);
	endfunction : write_hit

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [8:0] rd;
		logic [7:0] widx;
		logic [7:0] ctrl;
		logic [7:0] dimsel;
		logic       src;
		rd     = 9'h000;
		widx   = 8'h00;
		ctrl   = 8'h00;
		dimsel = 8'h00;
		src    = 1'b0;
		s_next = s_reg;

		// Millisecond prescaler for the sequencers
		s_next.tick = 1'b0;
		if (s_reg.presc == TICK_W'(TICK_CYCLES - 1)) begin
			s_next.presc = '0;
			s_next.tick  = 1'b1;
		end else begin
			s_next.presc = s_reg.presc + TICK_W'(1);
		end

		// Write channel: address and data held in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_next.aw_held = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.w_held = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.aw_held && s_reg.w_held) begin
			widx           = 8'(s_reg.aw_addr[ADDR_W-1:2]);
			s_next.aw_held = 1'b0;
			s_next.w_held  = 1'b0;
			s_next.bvalid  = 1'b1;
			s_next.bresp   = write_hit(widx) ? RESP_OKAY : RESP_SLVERR;
			if (s_reg.w_strb[0]) begin
				s_next.regs = write_reg(widx, s_reg.w_data[7:0], s_reg.regs);
			end
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end

		// Read channel: data one cycle after the address is taken
		if (s_axi_arvalid && !s_reg.rvalid) begin
			rd            = read_reg(s_axi_araddr, s_reg);
			s_next.rvalid = 1'b1;
			s_next.rdata  = {24'h000000, rd[7:0]};
			s_next.rresp  = rd[8] ? RESP_OKAY : RESP_SLVERR;
		end else if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end

		ctrl             = s_reg.regs.led_output_control;
		s_next.style_one = ctrl[`CLBC_BIT_GROUP_ONE_STYLE];
		s_next.style_two = ctrl[`CLBC_BIT_GROUP_TWO_STYLE];

		// Channel on state; bit 5 red one down to bit 0 blue two
		dimsel = s_reg.regs.external_dimming_select;
		for (int i = 0; i < 6; i++) begin
			src = ctrl[i];
			if (i >= 3 && blink_mode && s_reg.regs.cycle[i-3][`CLBC_BIT_BLINK_ENABLE]) begin
				src = lit[i-3];
			end
			s_next.drive[i] = src && (!dimsel[i] || ext_dim_in);
		end

		s_next.gate_a = !dimsel[`CLBC_BIT_WHITE_A_EXT_DIM] || ext_dim_in;
		s_next.gate_b = !dimsel[`CLBC_BIT_WHITE_B_EXT_DIM] || ext_dim_in;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s_reg                              <= '0;
			s_reg.regs.led_output_control      <= `CLBC_RST_LED_OUTPUT_CONTROL;
			s_reg.regs.external_dimming_select <= `CLBC_RST_OTHER;
			s_reg.style_one                    <= 1'b1;
			s_reg.style_two                    <= 1'b1;
			s_reg.gate_a                       <= 1'b1;
			s_reg.gate_b                       <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule : clbc_top

// ### clbc_top_asserts.sv
// Purpose: Port assertions for the colour LED block
// Assumes: A register shadow that commits one edge after the design does
// Notes  : Only the low byte of a write matters, as in the design
`timescale 1ns/1ps
`include "clbc_map.svh"
module clbc_top_asserts #(
	parameter int ADDR_W      = 8,
	parameter int TICK_CYCLES = 4
) (
	input wire logic              mclk,
	input wire logic              reset,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic [3:0]        s_axi_wstrb,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              ext_dim_in,
	input wire logic [5:0]        led_drive,
	input wire logic              group_one_driver_style,
	input wire logic              group_two_driver_style,
	input wire logic              white_bank_a_dim_gate,
	input wire logic              white_bank_b_dim_gate
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// ----------------------------------------
	// Register shadow
	// ----------------------------------------
	logic [7:0]      aw_a, w_d, sh_ctrl, sh_dim, sh_mode;
	logic [2:0][7:0] sh_oo, sh_cy;
	logic            w_s, bv_d;
	logic [2:0]      blk;
	logic            red_blink;

	// Commit on the rising response so shadow and outputs line up in sampling
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			{aw_a, w_d, w_s, bv_d, sh_dim, sh_mode, sh_oo, sh_cy} <= '0;
			sh_ctrl <= `CLBC_RST_LED_OUTPUT_CONTROL;
		end else begin
			bv_d <= s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
				aw_a <= 8'(s_axi_awaddr >> 2);
			if (s_axi_wvalid && s_axi_wready)
				{w_s, w_d} <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
			if (s_axi_bvalid && !bv_d && w_s) begin
				case (aw_a)
					8'h00: sh_ctrl <= w_d;
					8'h01: sh_oo[2] <= w_d;
					8'h02: sh_cy[2] <= w_d & 8'h0F;
					8'h03: sh_oo[1] <= w_d;
					8'h04: sh_cy[1] <= w_d & 8'h0F;
					8'h05: sh_oo[0] <= w_d;
					8'h06: sh_cy[0] <= w_d & 8'h0F;
					8'h07: sh_dim <= w_d;
					8'h10: sh_mode <= w_d & 8'h03;
					default: ;
				endcase
			end
		end
	end

	// Group one bits under blink control are skipped here; only red one has blink checks
	assign blk       = {3{sh_mode[1:0] == 2'h1}} & {sh_cy[2][3], sh_cy[1][3], sh_cy[0][3]};
	assign red_blink = blk[2] && !sh_dim[5];

	sequence red_held_s;
		(red_blink && $stable(sh_oo[2]))[*4];
	endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	style_one_a: assert property (group_one_driver_style == sh_ctrl[7])
		else $error("group one style differs from control bit");
	style_two_a: assert property (group_two_driver_style == sh_ctrl[6])
		else $error("group two style differs from control bit");
	group_two_a: assert property (led_drive[2:0] ==
		(sh_ctrl[2:0] & (~sh_dim[2:0] | {3{$past(ext_dim_in)}})))
		else $error("group two drive wrong");
	group_one_a: assert property (((led_drive[5:3] ^
		(sh_ctrl[5:3] & (~sh_dim[5:3] | {3{$past(ext_dim_in)}}))) & ~blk) == 3'h0)
		else $error("group one drive wrong outside blinking");
	white_a_a: assert property (white_bank_a_dim_gate == (!sh_dim[7] || $past(ext_dim_in)))
		else $error("white bank a gate wrong");
	white_b_a: assert property (white_bank_b_dim_gate == (!sh_dim[6] || $past(ext_dim_in)))
		else $error("white bank b gate wrong");
	blink_dark_a: assert property (red_held_s ##0 sh_oo[2][7:4] == 4'h0 |-> !led_drive[5])
		else $error("red lit with zero on share");
	blink_full_a: assert property (red_held_s ##0 sh_oo[2] == 8'hF0 |-> led_drive[5])
		else $error("red dark with full on share");
endmodule : clbc_top_asserts

bind clbc_top clbc_top_asserts #(.ADDR_W(ADDR_W), .TICK_CYCLES(TICK_CYCLES)) u_clbc_top_asserts (
	.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .ext_dim_in, .led_drive,
	.group_one_driver_style, .group_two_driver_style, .white_bank_a_dim_gate,
	.white_bank_b_dim_gate);

// ### clbc_led_model.sv
// Purpose: Far-side model of the LED pins and the external dim source
// Assumes: Runs on mclk; the bench picks the dim source mode
// Notes  : Measures red one pulses so blink timing can be judged
`timescale 1ns/1ps
module clbc_led_model (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic [1:0] dim_mode,
	input  wire logic       red_led,
	output logic            ext_dim,
	output int              hi_len,
	output int              gap,
	output int              rises
);
	int         hi_cnt, gap_cnt;
	logic       red_d;
	logic [2:0] div;

	// Dim source low, high or a square wave; red pulse width and spacing counted
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			{ext_dim, red_d, div} <= '0;
			{hi_len, gap, rises, hi_cnt, gap_cnt} <= '0;
		end else begin
			red_d   <= red_led;
			div     <= div + 3'h1;
			ext_dim <= (dim_mode == 2'h2) ? div[2] : dim_mode[0];
			hi_cnt  <= red_led ? hi_cnt + 1 : 0;
			gap_cnt <= (red_led && !red_d) ? 1 : gap_cnt + 1;
			if (red_led && !red_d) begin
				rises <= rises + 1;
				gap   <= gap_cnt;
			end
			if (!red_led && red_d)
				hi_len <= hi_cnt;
		end
	end
endmodule : clbc_led_model

// ### clbc_top_bench.sv
// Purpose: Self-checking bench for the colour LED block
// Assumes: TICK_CYCLES shortened so a blink millisecond is two clocks
// Notes  : Random register data come from a 16-bit LFSR with a fixed start
`timescale 1ns/1ps
module clbc_top_bench;
	localparam int TICK = 2;
	logic        mclk, reset, ext_dim_in, style_one, style_two, gate_a, gate_b;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, ctrl, dim;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, dim_mode;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [5:0]  led_drive;
	logic [15:0] seed;
	int          errors, n_tests, hi_len, gap, rises;

	clbc_top #(.ADDR_W(8), .TICK_CYCLES(TICK)) u_clbc_top (.mclk(mclk), .reset(reset),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_dim_in(ext_dim_in),
		.led_drive(led_drive), .group_one_driver_style(style_one),
		.group_two_driver_style(style_two), .white_bank_a_dim_gate(gate_a),
		.white_bank_b_dim_gate(gate_b));
	clbc_led_model u_clbc_led_model (.mclk(mclk), .reset(reset), .dim_mode(dim_mode),
		.red_led(led_drive[5]), .ext_dim(ext_dim_in), .hi_len(hi_len), .gap(gap), .rises(rises));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// Share of a period in ms for a four-bit on or off code, rounded down
	function automatic int share_ms(input int per, input logic [3:0] c);
		int t[16] = '{0, 10, 25, 50, 75, 100, 150, 200, 300, 400, 500, 600, 700, 800, 900, 1000};
		return per * t[c] / 1000;
	endfunction : share_ms

	// Write holds each channel until taken; bready stays up until the answer
	task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st,
		input logic [1:0] er);
		bit b_ok;
		@(posedge mclk);
		{s_axi_awaddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {idx[5:0], 2'h0, 3'h7};
		s_axi_wdata <= {seed, seed[7:0], d};
		s_axi_wstrb <= st;
		while (!b_ok) begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				b_ok = 1'b1;
				s_axi_bready <= 1'b0;
				check(s_axi_bresp, er);
			end
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
		@(posedge mclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {idx[5:0], 2'h0, 2'h3};
		do begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, exp);
		check(s_axi_rresp, er);
	endtask : axi_rd

	// Restart red blinking and measure a steady pulse after two full periods
	task automatic blink_run(input logic [2:0] p, input logic [3:0] on, input logic [3:0] off);
		int per[8] = '{100, 250, 500, 1000, 2000, 3000, 4000, 5000};
		int hi, r0;
		hi = share_ms(per[p], on);
		if (per[p] - share_ms(per[p], off) < hi)
			hi = per[p] - share_ms(per[p], off);
		axi_wr(8'h02, 8'h00, 4'hF, 2'h0);
		axi_wr(8'h01, {on, off}, 4'hF, 2'h0);
		axi_wr(8'h02, {5'h01, p}, 4'hF, 2'h0);
		r0 = rises;
		for (int k = 0; k < 3 * per[p] * TICK + 50 && rises < r0 + 3; k++)
			@(posedge mclk);
		check(gap, per[p] * TICK);
		check(hi_len, hi * TICK);
	endtask : blink_run

	// ----------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Expected run is near 72k cycles; a hang still ends the run below 100k cycles
	initial begin
		repeat (95000) @(posedge mclk);
		errors++;
		wrap_up();
	end

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, dim_mode} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		errors = 0;
		n_tests = 0;
		seed = 16'h4B5C;
		reset = 1'b1;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		check({style_one, style_two, gate_a, gate_b, led_drive}, 10'h3C0);
		for (int i = 0; i < 9; i++)
			axi_rd(i == 8 ? 8'h10 : 8'(i), i == 0 ? 32'hC0 : 32'h0, 2'h0);
		axi_rd(8'h20, 32'h0, 2'h2);
		axi_wr(8'h20, 8'h5A, 4'hF, 2'h2);
		axi_wr(8'h11, 8'h3F, 4'hF, 2'h0);
		axi_wr(8'h02, 8'hFF, 4'hF, 2'h0);
		axi_rd(8'h02, 32'h0F, 2'h0);
		ctrl = 8'hC0;
		// Random control bytes, some with the low strobe off
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			axi_wr(8'h00, seed[7:0], seed[9:8] == 2'h0 ? 4'hE : 4'hF, 2'h0);
			if (seed[9:8] != 2'h0)
				ctrl = seed[7:0];
			repeat (2) @(posedge mclk);
			check({style_one, style_two, led_drive}, ctrl);
			axi_rd(8'h00, {24'h0, ctrl}, 2'h0);
			axi_rd(8'h11, {26'h0, ctrl[5:0]}, 2'h0);
		end
		// Hand one output at a time to the dim input, held low then high
		axi_wr(8'h00, 8'h3F, 4'hF, 2'h0);
		for (int i = 0; i < 16; i++) begin
			dim = 8'h01 << i[2:0];
			dim_mode <= {1'b0, i[3]};
			axi_wr(8'h07, dim, 4'hF, 2'h0);
			repeat (3) @(posedge mclk);
			check({gate_a, gate_b, led_drive},
				{~dim[7:6] | {2{i[3]}}, 6'h3F & (~dim[5:0] | {6{i[3]}})});
		end
		seed = lfsr(seed);
		dim_mode <= 2'h2;
		axi_wr(8'h07, seed[7:0], 4'hF, 2'h0);
		repeat (200) @(posedge mclk);
		dim_mode <= 2'h1;
		axi_wr(8'h07, 8'h00, 4'hF, 2'h0);
		// Blink enabled but mode not selected: red follows its enable
		axi_wr(8'h00, 8'h20, 4'hF, 2'h0);
		axi_wr(8'h01, 8'hA0, 4'hF, 2'h0);
		axi_wr(8'h02, 8'h08, 4'hF, 2'h0);
		axi_wr(8'h10, 8'hFE, 4'hF, 2'h0);
		repeat (400) @(posedge mclk);
		check(led_drive, 6'h20);
		axi_wr(8'h10, 8'h01, 4'hF, 2'h0);
		axi_wr(8'h00, 8'h00, 4'hF, 2'h0);
		axi_wr(8'h01, 8'hF0, 4'hF, 2'h0);
		axi_wr(8'h03, 8'hF0, 4'hF, 2'h0);
		axi_wr(8'h04, 8'h0B, 4'hF, 2'h0);
		axi_wr(8'h06, 8'h08, 4'hF, 2'h0);
		repeat (20) @(posedge mclk);
		check(led_drive, 6'h30);
		axi_wr(8'h01, 8'h00, 4'hF, 2'h0);
		repeat (20) @(posedge mclk);
		for (int c = 1; c < 15; c++)
			blink_run(3'h0, 4'(c), 4'h0);
		for (int p = 0; p < 8; p++) begin
			seed = lfsr(seed);
			blink_run(3'(p), 4'(1 + seed[3:0] % 14), 4'h3);
		end
		wrap_up();
	end
endmodule : clbc_top_bench
